// *** rtl/aio_route_defines.svh ***
// offsets, field positions, reset values and limits of the analogue routing block
`ifndef AIO_ROUTE_DEFINES_SVH
`define AIO_ROUTE_DEFINES_SVH

`define PARAM_W         11
`define SCALE_DIV       1000
`define VAL_MAX         1000
`define NUM_PARAM       28

// register indices, byte address = 4 * index
`define IDX_GP1_VAL     5'd0
`define IDX_SPD_IN      5'd4
`define IDX_LINE_V      5'd5
`define IDX_STACK_T     5'd6
`define IDX_OUT1_SRC    5'd7
`define IDX_GP1_DEST    5'd10
`define IDX_SPD_DEST    5'd14
`define IDX_GP1_SCALE   5'd15
`define IDX_SPD_SCALE   5'd19
`define IDX_OUT1_SCALE  5'd20
`define IDX_ENC_SCALE   5'd23
`define IDX_REF_SEL     5'd24
`define IDX_CUR_SEL     5'd25
`define IDX_CUR_INV     5'd26
`define IDX_OFS_SEL     5'd27
`define IDX_IRQ_STAT    5'd28
`define IDX_IRQ_MASK    5'd29

// reset values
`define RST_GP1_DEST    11'h13e
`define RST_GP2_DEST    11'h077
`define RST_GP3_DEST    11'h078
`define RST_GP4_DEST    11'h198
`define RST_SPD_DEST    11'h075
`define RST_SCALE       11'h3e8
`define RST_ENC_SCALE   11'h1a3
`define RST_OUT1_SRC    11'h0c9
`define RST_OUT2_SRC    11'h12e
`define RST_OUT3_SRC    11'h130
`define RST_OFS_SEL     11'h001

// loop current in 10 uA steps
`define LOOP_FULL       2000
`define LOOP_OFFSET     400
`define LOOP_SPAN       1600
`define LOOP_OPEN_LIM   11'd350

// status bits
`define ST_LOOP_OPEN    0
`define ST_SATURATE     1
`define ST_W            2

`endif

// *** rtl/aio_route_pkg.sv ***
// types of the analogue routing block
package aio_route_pkg;
	typedef logic signed [10:0] sval_t;
	typedef logic        [10:0] param_t;

	typedef struct packed {
		sval_t [3:0]        gp;
		sval_t              speed_term;
		logic        [10:0] loop_cur;
		logic signed [15:0] enc_rate;
		logic        [9:0]  line_v;
		logic        [9:0]  stack_t;
		logic               apply;
	} pins_t;

	typedef struct packed {
		param_t dest;
		sval_t  value;
	} route_t;

	typedef struct packed {
		logic  sat;
		sval_t value;
	} scaled_t;
endpackage

// *** rtl/aio_route.sv ***
// analogue input routing, output source selection and scaling with wishbone registers
// Overview of operation
// - four general inputs readable, clamped to 1000
// - speed input from terminal or encoder
// - each output reads its selected source parameter
// - general inputs go to their destination parameter
// - scaled speed reference goes to destination
// - new destination takes effect only after reset
// - selectors encode menu times hundred plus index
// - scaling value over 1000 is the multiplier
// - speed output is input times scale/1000
// - output channel value times own scale/1000
// - encoder scaling defaults to 419
// - reference select: 0 terminal, 1 encoder
// - current select: 0 voltage, 1 current loop
// - invert and offset bits pick loop mode
// - line voltage and temperature read 0..1000
// - four loop modes, 0/4 to 20 mA
// - offset mode trips below 3.5 mA
`timescale 1ns/100ps
`default_nettype none
`include "aio_route_defines.svh"

module aio_route
	import aio_route_pkg::*;
(
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	input  wire logic                cyc_i,
	input  wire logic                stb_i,
	input  wire logic                we_i,
	input  wire logic [7:0]          adr_i,
	input  wire logic [3:0]          sel_i,
	input  wire logic [31:0]         dat_i,
	output logic      [31:0]         dat_o,
	output logic                     ack_o,
	input  wire pins_t               pins_i,
	input  wire sval_t [2:0]         out_src_val_i,
	output route_t    [4:0]          route_o,
	output param_t    [2:0]          out_src_o,
	output sval_t     [2:0]          out_val_o,
	output logic                     loop_trip_o,
	output logic                     irq_o
);

	pins_t                  pin_meta_q;
	pins_t                  pin_q;
	logic                   apply_prev_q;
	param_t                 par_q [0:`NUM_PARAM-1];
	param_t   [4:0]         active_q;
	sval_t    [4:0]         in_q;
	logic     [9:0]         line_q;
	logic     [9:0]         temp_q;
	logic     [`ST_W-1:0]   stat_q;
	logic     [`ST_W-1:0]   mask_q;
	logic     [`ST_W-1:0]   stat_set;
	logic     [4:0]         idx;
	logic                   req;
	logic                   wr_en;
	logic                   stat_rd;
	logic                   apply_edge;
	logic     [4:0]         route_sat;
	logic     [2:0]         out_sat;
	logic     [31:0]        rd_d;
	logic     [10:0]        wr_val;
	sval_t                  loop_val;
	sval_t                  speed_sel;
	scaled_t                enc_scaled;

	// wide product divided down; the clamp keeps overflow from wrapping
	function automatic scaled_t scale_val(input logic signed [15:0] v, input param_t s);
		logic signed [28:0] prod;
		logic signed [28:0] quo;
		scaled_t            r;
		prod = 29'(v) * $signed({18'h0, s});
		quo = prod / 29'sd1000;
		r.sat = 1'b0;
		if (quo > 29'sd1000) begin
			r.value = 11'sd1000;
			r.sat = 1'b1;
		end else if (quo < -29'sd1000) begin
			r.value = -11'sd1000;
			r.sat = 1'b1;
		end else begin
			r.value = quo[10:0];
		end
		return r;
	endfunction

	function automatic sval_t clamp_in(input sval_t v);
		if (v > 11'sd1000)
			return 11'sd1000;
		else if (v < -11'sd1000)
			return -11'sd1000;
		return v;
	endfunction

	function automatic param_t par_default(input int i);
		case (i)
			10:      return `RST_GP1_DEST;
			11:      return `RST_GP2_DEST;
			12:      return `RST_GP3_DEST;
			13:      return `RST_GP4_DEST;
			14:      return `RST_SPD_DEST;
			15, 16, 17, 18, 19, 20, 21, 22: return `RST_SCALE;
			23:      return `RST_ENC_SCALE;
			7:       return `RST_OUT1_SRC;
			8:       return `RST_OUT2_SRC;
			9:       return `RST_OUT3_SRC;
			27:      return `RST_OFS_SEL;
			default: return 11'h000;
		endcase
	endfunction

	// pins come from converters outside this clock
	always_ff @(posedge clk_i) begin
		pin_meta_q <= pins_i;
		pin_q <= pin_meta_q;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			apply_prev_q <= 1'b0;
		else
			apply_prev_q <= pin_q.apply;
	end
	assign apply_edge = pin_q.apply & ~apply_prev_q;

	// wishbone slave: ack one cycle after the request, write on the ack edge
	assign req = cyc_i & stb_i;
	assign idx = adr_i[6:2];
	assign wr_en = req & ack_o & we_i & ~adr_i[7];
	assign stat_rd = req & ack_o & ~we_i & ~adr_i[7] & (idx == `IDX_IRQ_STAT);
	assign wr_val = {sel_i[1] ? dat_i[10:8] : 3'h0, sel_i[0] ? dat_i[7:0] : 8'h00};

	always_ff @(posedge clk_i) begin
		if (rst_i)
			ack_o <= 1'b0;
		else
			ack_o <= req & ~ack_o;
	end

	// byte lanes merge into the old value
	for (genvar g = 0; g < `NUM_PARAM; g++) begin : g_par
		always_ff @(posedge clk_i) begin
			if (rst_i)
				par_q[g] <= par_default(g);
			else if (wr_en && idx == 5'(g) && g >= 7) begin
				if (sel_i[0])
					par_q[g][7:0] <= dat_i[7:0];
				if (sel_i[1])
					par_q[g][10:8] <= dat_i[10:8];
			end
		end
	end

	always_comb begin
		rd_d = 32'h0000_0000;
		if (adr_i[7])
			rd_d = 32'h0000_0000;
		else if (idx < `IDX_SPD_IN)
			rd_d = {{21{in_q[idx[1:0]][10]}}, in_q[idx[1:0]]};
		else if (idx == `IDX_SPD_IN)
			rd_d = {{21{in_q[4][10]}}, in_q[4]};
		else if (idx == `IDX_LINE_V)
			rd_d = {22'h0, line_q};
		else if (idx == `IDX_STACK_T)
			rd_d = {22'h0, temp_q};
		else if (idx < `IDX_IRQ_STAT)
			rd_d = {21'h0, par_q[idx]};
		else if (idx == `IDX_IRQ_STAT)
			rd_d = {30'h0, stat_q};
		else if (idx == `IDX_IRQ_MASK)
			rd_d = {30'h0, mask_q};
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			dat_o <= 32'h0000_0000;
		else if (req && !ack_o && !we_i)
			dat_o <= rd_d;
	end

	// current loop conversion, result 0..1000 before speed scaling
	always_comb begin
		logic [11:0] cur;
		logic [11:0] lin;
		cur = {1'b0, pin_q.loop_cur};
		lin = 12'h000;
		if (par_q[`IDX_OFS_SEL][0]) begin
			if (cur > 12'(`LOOP_OFFSET))
				lin = 12'((32'(cur) - `LOOP_OFFSET) * 5 / 8);
		end else begin
			lin = cur >> 1;
		end
		if (lin > 12'd1000)
			lin = 12'd1000;
		if (par_q[`IDX_CUR_INV][0])
			lin = 12'd1000 - lin;
		loop_val = sval_t'(lin[10:0]);
	end

	assign enc_scaled = scale_val(pin_q.enc_rate, par_q[`IDX_ENC_SCALE]);

	always_comb begin
		if (par_q[`IDX_REF_SEL][0])
			speed_sel = enc_scaled.value;
		else if (par_q[`IDX_CUR_SEL][0])
			speed_sel = loop_val;
		else
			speed_sel = clamp_in(pin_q.speed_term);
	end

	// monitored input values
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			in_q <= '0;
			line_q <= 10'h000;
			temp_q <= 10'h000;
		end else begin
			for (int i = 0; i < 4; i++)
				in_q[i] <= clamp_in(pin_q.gp[i]);
			in_q[4] <= speed_sel;
			line_q <= (pin_q.line_v > 10'd1000) ? 10'd1000 : pin_q.line_v;
			temp_q <= (pin_q.stack_t > 10'd1000) ? 10'd1000 : pin_q.stack_t;
		end
	end

	// destinations latched only by the reset pushbutton
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			active_q[0] <= `RST_GP1_DEST;
			active_q[1] <= `RST_GP2_DEST;
			active_q[2] <= `RST_GP3_DEST;
			active_q[3] <= `RST_GP4_DEST;
			active_q[4] <= `RST_SPD_DEST;
		end else if (apply_edge) begin
			for (int i = 0; i < 5; i++)
				active_q[i] <= par_q[`IDX_GP1_DEST + 5'(i)];
		end
	end

	// destination numbers are menu*100+item, passed on unchanged
	for (genvar g = 0; g < 5; g++) begin : g_route
		scaled_t sc;
		assign sc = scale_val(16'(in_q[g]), par_q[`IDX_GP1_SCALE + 5'(g)]);
		assign route_sat[g] = sc.sat;
		always_ff @(posedge clk_i) begin
			if (rst_i)
				route_o[g] <= '{dest: 11'h000, value: 11'sh000};
			else
				route_o[g] <= '{dest: active_q[g], value: sc.value};
		end
	end

	for (genvar g = 0; g < 3; g++) begin : g_out
		scaled_t sc;
		assign sc = scale_val(16'(out_src_val_i[g]), par_q[`IDX_OUT1_SCALE + 5'(g)]);
		assign out_sat[g] = sc.sat;
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				out_src_o[g] <= par_default(7 + g);
				out_val_o[g] <= 11'sh000;
			end else begin
				out_src_o[g] <= par_q[`IDX_OUT1_SRC + 5'(g)];
				out_val_o[g] <= sc.value;
			end
		end
	end

	// trip holds while the loop reads open
	always_ff @(posedge clk_i) begin
		if (rst_i)
			loop_trip_o <= 1'b0;
		else
			loop_trip_o <= par_q[`IDX_OFS_SEL][0] & (pin_q.loop_cur < `LOOP_OPEN_LIM);
	end

	// read clears status, a set in the same cycle wins
	// only bits the read reported are cleared, so a set after capture survives
	assign stat_set[`ST_LOOP_OPEN] = loop_trip_o;
	assign stat_set[`ST_SATURATE] = |route_sat | |out_sat;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stat_q <= '0;
			mask_q <= '0;
			irq_o <= 1'b0;
		end else begin
			stat_q <= (stat_q & ~(dat_o[`ST_W-1:0] & {`ST_W{stat_rd}})) | stat_set;
			if (wr_en && idx == `IDX_IRQ_MASK && sel_i[0])
				mask_q <= wr_val[`ST_W-1:0];
			irq_o <= |(stat_q & mask_q);
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	ack_pulse_a: assert property (ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");
	ack_answer_a: assert property (req && !ack_o |=> ack_o)
		else $error("request not answered in one cycle");
	dest_hold_a: assert property (!apply_edge |=> $stable(active_q))
		else $error("destination changed without reset");
	dest_apply_a: assert property (apply_edge |=> ##1
		route_o[4].dest == $past(par_q[`IDX_SPD_DEST], 2))
		else $error("speed destination not applied");
	route_range_a: assert property (route_o[0].value <= 11'sd1000 && route_o[0].value >= -11'sd1000)
		else $error("routed value outside range");
	trip_open_a: assert property (par_q[`IDX_OFS_SEL][0] && pin_q.loop_cur < `LOOP_OPEN_LIM
		&& $stable(par_q[`IDX_OFS_SEL]) |=> loop_trip_o)
		else $error("loop open not tripped");
	no_trip_a: assert property (!par_q[`IDX_OFS_SEL][0] |=> !loop_trip_o)
		else $error("trip without offset mode");
	line_range_a: assert property (line_q <= 10'd1000 && temp_q <= 10'd1000)
		else $error("monitor value above 1000");
	src_reset_a: assert property ($fell(rst_i) |-> out_src_o[0] == `RST_OUT1_SRC
		&& out_src_o[2] == `RST_OUT3_SRC)
		else $error("output source default wrong");
	stat_sticky_a: assert property (stat_q[`ST_LOOP_OPEN] && !stat_rd |=> stat_q[`ST_LOOP_OPEN])
		else $error("status bit lost without read");
	irq_follow_a: assert property (stat_q[`ST_LOOP_OPEN] && mask_q[`ST_LOOP_OPEN]
		&& !stat_rd ##1 1 |-> irq_o)
		else $error("interrupt not raised");

	// bus, status and source selection bookkeeping, one edge after the request or event
	stat_clear_a: assert property (stat_rd && dat_o[`ST_LOOP_OPEN] && !stat_set[`ST_LOOP_OPEN]
		|=> !stat_q[`ST_LOOP_OPEN])
		else $error("status bit not cleared by read");
	stat_keep_a: assert property (stat_rd && stat_q[`ST_LOOP_OPEN] && !dat_o[`ST_LOOP_OPEN]
		|=> stat_q[`ST_LOOP_OPEN])
		else $error("unreported status bit cleared");
	ack_idle_a: assert property (!req |=> !ack_o)
		else $error("ack without request");
	write_land_a: assert property (wr_en && idx == `IDX_SPD_SCALE && sel_i[1:0] == 2'b11
		|=> par_q[`IDX_SPD_SCALE] == $past(dat_i[10:0]))
		else $error("write did not land");
	mask_write_a: assert property (wr_en && idx == `IDX_IRQ_MASK && sel_i[0]
		|=> mask_q == $past(dat_i[`ST_W-1:0]))
		else $error("mask write did not land");
	mask_read_a: assert property (req && !ack_o && !we_i && !adr_i[7] && idx == `IDX_IRQ_MASK
		|=> dat_o == {30'h0, $past(mask_q)})
		else $error("mask read data wrong");
	read_zero_a: assert property (req && !ack_o && !we_i && adr_i[7]
		|=> dat_o == 32'h0000_0000)
		else $error("unmapped read not zero");
	irq_clear_a: assert property (!(|(stat_q & mask_q)) |=> !irq_o)
		else $error("interrupt without masked status");
	sat_flag_a: assert property ((|route_sat) |=> stat_q[`ST_SATURATE])
		else $error("saturation not flagged");
	src_follow_a: assert property (1'b1
		|=> out_src_o[1] == $past(par_q[`IDX_OUT1_SRC + 5'd1]))
		else $error("output source not followed");
	enc_path_a: assert property (par_q[`IDX_REF_SEL][0]
		|=> in_q[4] == $past(enc_scaled.value))
		else $error("encoder not chosen as speed source");
	loop_path_a: assert property (!par_q[`IDX_REF_SEL][0] && par_q[`IDX_CUR_SEL][0]
		|=> in_q[4] == $past(loop_val))
		else $error("loop value not chosen as speed source");

	apply_c: cover property (apply_edge ##2 route_o[0].dest != `RST_GP1_DEST);
	trip_c: cover property (loop_trip_o ##[1:4] irq_o);
	sat_c: cover property (stat_set[`ST_SATURATE]);
	encoder_c: cover property (par_q[`IDX_REF_SEL][0] && in_q[4] != 11'sh000);
	// inverted loop is the mode least likely to be exercised by accident
	loop_mode_c: cover property (par_q[`IDX_CUR_SEL][0] && par_q[`IDX_CUR_INV][0]);

endmodule
`default_nettype wire

// *** tb/aio_route_test.sv ***
// self-checking bench for the analogue routing block
`timescale 1ns/100ps
`default_nettype none

module aio_route_test
	import aio_route_pkg::*;
;
	logic                clk_i = 1'b0;
	logic                rst_i = 1'b1;
	logic                cyc_i = 1'b0;
	logic                stb_i = 1'b0;
	logic                we_i = 1'b0;
	logic        [7:0]   adr_i = 8'h00;
	logic        [3:0]   sel_i = 4'h3;
	logic        [31:0]  dat_i = 32'h0;
	logic        [31:0]  dat_o;
	logic                ack_o;
	pins_t               pins;
	sval_t       [2:0]   osv = '0;
	route_t      [4:0]   route_o;
	param_t      [2:0]   out_src_o;
	sval_t       [2:0]   out_val_o;
	logic                loop_trip_o;
	logic                irq_o;
	logic        [32:0]  q[$];
	logic        [32:0]  e;
	int                  num_errors = 0;
	int                  check_count = 0;
	int                  cyc_cnt = 0;
	int                  seed = 22540;
	int                  i;
	int                  g[4];
	int                  v[3];
	param_t              rv[21] = '{11'h0c9, 11'h12e, 11'h130, 11'h13e, 11'h077, 11'h078,
		11'h198, 11'h075, 11'h3e8, 11'h3e8, 11'h3e8, 11'h3e8, 11'h3e8, 11'h3e8, 11'h3e8,
		11'h3e8, 11'h1a3, 11'h000, 11'h000, 11'h000, 11'h001};
	int                  lm[4] = '{600, 500, 400, 500};

	aio_route u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
		.ack_o(ack_o), .pins_i(pins), .out_src_val_i(osv), .route_o(route_o),
		.out_src_o(out_src_o), .out_val_o(out_val_o), .loop_trip_o(loop_trip_o),
		.irq_o(irq_o));

	always #12.5 clk_i = ~clk_i;

	task automatic chk(input logic [31:0] a, input logic [31:0] b);
		check_count++;
		if (a !== b) begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, a, b);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// timeout guard, the whole run needs a few hundred cycles
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			num_errors++;
			end_sim();
		end
	end

	// read data taken only at the edge where ack is seen
	always @(posedge clk_i) begin
		if (ack_o === 1'b1 && we_i === 1'b0 && q.size() > 0) begin
			e = q.pop_front();
			if (e[32]) begin
				chk(dat_o, e[31:0]);
			end
		end
	end

	task automatic wb(input logic w, input int x, input logic [31:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= 8'(4 * x);
		dat_i <= d;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask

	task automatic rd(input int x, input logic [31:0] d, input logic c);
		q.push_back({c, d});
		wb(1'b0, x, 32'h0);
	endtask

	task automatic w(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	initial begin
		pins = '0;
		pins.loop_cur = 11'h7d0;
		w(3);
		rst_i <= 1'b0;
		w(3);
		for (i = 0; i < 21; i++) rd(i + 7, rv[i], 1'b1);
		for (i = 0; i < 5; i++) chk(route_o[i].dest, rv[i + 3]);
		for (i = 0; i < 3; i++) chk(out_src_o[i], rv[i]);
		rd(32, 32'h0, 1'b1);
		rd(28, 32'h0, 1'b0);
		// loop open sets the sticky bit; it stays set after the loop is back until a status read clears it
		pins.loop_cur <= 11'h064;
		w(10);
		chk(loop_trip_o, 1'b1);
		wb(1'b1, 29, 32'h1);
		w(2);
		chk(irq_o, 1'b1);
		pins.loop_cur <= 11'h7d0;
		w(10);
		chk(loop_trip_o, 1'b0);
		rd(28, 32'h1, 1'b1);
		rd(28, 32'h0, 1'b1);
		w(2);
		chk(irq_o, 1'b0);
		for (i = 0; i < 4; i++) begin
			g[i] = ($random(seed) % 500) * 2;
			pins.gp[i] <= sval_t'(g[i]);
			wb(1'b1, 15 + i, 32'h1f4);
		end
		pins.line_v <= 10'({$random(seed)} % 1001);
		pins.stack_t <= 10'h3e8;
		w(10);
		for (i = 0; i < 4; i++) begin
			rd(i, 32'(sval_t'(g[i])), 1'b1);
			chk(route_o[i].value, sval_t'(g[i] / 2));
		end
		rd(5, 32'(pins.line_v), 1'b1);
		rd(6, 32'h3e8, 1'b1);
		wb(1'b1, 10, 32'h12d);
		w(5);
		chk(route_o[0].dest, 11'h13e);
		pins.apply <= 1'b1;
		w(6);
		pins.apply <= 1'b0;
		w(6);
		chk(route_o[0].dest, 11'h12d);
		g[0] = ($random(seed) % 250) * 4;
		pins.speed_term <= sval_t'(g[0]);
		wb(1'b1, 19, 32'h0fa);
		w(10);
		rd(4, 32'(sval_t'(g[0])), 1'b1);
		chk(route_o[4].value, sval_t'(g[0] / 4));
		for (i = 0; i < 3; i++) begin
			v[i] = ($random(seed) % 300) * 2;
			osv[i] <= sval_t'(v[i]);
			wb(1'b1, 20 + i, 32'h5dc);
		end
		wb(1'b1, 7, 32'h12d);
		w(4);
		chk(out_src_o[0], 11'h12d);
		for (i = 0; i < 3; i++) chk(out_val_o[i], sval_t'(v[i] * 3 / 2));
		pins.enc_rate <= 16'sd1000;
		wb(1'b1, 24, 32'h1);
		w(10);
		rd(4, 32'h1a3, 1'b1);
		wb(1'b1, 24, 32'h0);
		wb(1'b1, 25, 32'h1);
		pins.loop_cur <= 11'h4b0;
		for (i = 0; i < 4; i++) begin
			wb(1'b1, 26, 32'(i / 2));
			wb(1'b1, 27, 32'(i % 2));
			w(10);
			rd(4, 32'(lm[i]), 1'b1);
		end
		rd(28, 32'h0, 1'b0);
		pins.gp[0] <= 11'sd1000;
		wb(1'b1, 15, 32'h7cf);
		w(10);
		chk(route_o[0].value, sval_t'(1000));
		pins.gp[0] <= -11'sd900;
		w(10);
		chk(route_o[0].value, sval_t'(-1000));
		rd(28, 32'h2, 1'b1);
		w(2);
		chk(q.size(), 0);
		end_sim();
	end
endmodule

`default_nettype wire
